// ### inc/tmr16_params.svh
// Purpose: named constants of the sixteen-bit timer unit
// Assumes: 12-bit APB byte address, 32-bit data
// Notes: byte addresses of the register words
`ifndef TMR16_PARAMS_SVH
`define TMR16_PARAMS_SVH

// ********************************
// register map
// ********************************
`define TMR_ADDR_W 12
`define TMR_OFS_MODE 12'hFA0
`define TMR_OFS_COUNT 12'hFA4
`define TMR_OFS_CMP 12'hFA8
`define TMR_OFS_TOE 12'hFAC
`define TMR_OFS_STATUS 12'hFB0
`define TMR_OFS_IE 12'hFB4
`define TMR_OFS_PORT 12'hFB8
`define TMR_OFS_RESTART 12'hFBC

// ********************************
// field positions
// ********************************
`define TMR_MODE_EN_BIT 2
`define TMR_MODE_RESTART_BIT 3
`define TMR_MODE_FREQ_LSB 4
`define TMR_MODE_FREQ_MSB 5
`define TMR_MODE_SRC_BIT 6
`define TMR_FLAG_BIT 0
`define TMR_LATCH_BIT 1
`define TMR_PORT_DIR_BIT 0
`define TMR_PORT_LATCH_BIT 1
`define TMR_LO_BYTE 0
`define TMR_HI_BYTE 1
`define TMR_TOE_BIT 0
`define TMR_IE_BIT 0
`define TMR_SOLO_RESTART_BIT 0
`define TMR_BYTE0_RANGE 7:0
`define TMR_BYTE1_RANGE 15:8

// ********************************
// reset values and widths
// ********************************
`define TMR_CNT_W 16
`define TMR_CNT_RESET 16'h0000
`define TMR_CMP_RESET 16'hFFFF
`define TMR_DATA_W 32
`define TMR_STRB_W 4
`define TMR_PREDIV_W 10
`define TMR_DIV0_W 10
`define TMR_DIV1_W 8
`define TMR_DIV2_W 6
`define TMR_DIV3_W 4

`endif

// ### inc/tmr_pkg.sv
// Purpose: types of the sixteen-bit timer unit
// Assumes: constants come from tmr16_params.svh
// Notes: whole block state is one packed struct
`include "tmr16_params.svh"

package tmr_pkg;

  typedef logic [`TMR_ADDR_W-1:0] tmr_addr_t;
  typedef logic [`TMR_DATA_W-1:0] tmr_word_t;
  typedef logic [`TMR_STRB_W-1:0] tmr_strb_t;
  typedef logic [`TMR_CNT_W-1:0] tmr_cnt_t;
  typedef logic [`TMR_PREDIV_W-1:0] tmr_prediv_t;
  typedef logic [1:0] tmr_freq_t;

  typedef struct packed {
    logic mode_en;
    logic src_sel;
    tmr_freq_t freq_sel;
    logic restart;
    tmr_cnt_t cnt;
    tmr_cnt_t cmp;
    logic toe;
    logic flag;
    logic tol;
    logic ie;
    logic port_dir;
    logic port_latch;
    tmr_prediv_t prediv;
    logic sync1;
    logic sync2;
    logic sync3;
    logic pin_out;
    tmr_word_t rdata;
  } tmr_state_t;

  localparam tmr_state_t TMR_ST_RESET = '{
    mode_en: 1'b0,
    src_sel: 1'b0,
    freq_sel: 2'h0,
    restart: 1'b0,
    cnt: `TMR_CNT_RESET,
    cmp: `TMR_CMP_RESET,
    toe: 1'b0,
    flag: 1'b0,
    tol: 1'b0,
    ie: 1'b0,
    port_dir: 1'b0,
    port_latch: 1'b0,
    prediv: '0,
    sync1: 1'b0,
    sync2: 1'b0,
    sync3: 1'b0,
    pin_out: 1'b0,
    rdata: '0
  };

endpackage : tmr_pkg

// ### hdl/tmr16_timer.sv
// Purpose: sixteen_bit_timer_unit, timer and event counter with APB registers
// Assumes: pclk is the system clock, ext pin is asynchronous
// Notes: zero wait-state APB slave, read data registered in setup phase
// ********************************
// Overview of operation
// - event mode: count grows once per selected edge on the ext pin
// - source 0: edge field 00 counts rising, 01 counts falling edges
// - source 1: clock divided by 2^10, 2^8, 2^6 or 2^4
// - count only while enable bit 2 is one, else hold the count
// - writing mode bit 3 clears count, flag and latch; bit self-clears
// - reset clears all mode bits, timer comes up disabled
// - mode is write-only: all its bits read as zero, bits 7, 1 and 0 unused
// - mode written as a byte; restart bit also writable alone
// - count is read-only in two bytes, resets to zero
// - count equal to compare sets match flag and requests interrupt
// - every match inverts the output toggle latch
// - match interval is compare plus one count periods
// - compare is 16 bits, written in bytes, resets to FFFF
// - pin output enable flag is read/write, resets to zero
// - pin carries latch only with enable, output direction, latch zero
// - external source with output on divides the ext pin signal
// - after a match count returns to zero and keeps counting
// - match request passed on only while interrupt enable is one
// ********************************
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "tmr16_params.svh"

module tmr16_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmr_pkg::tmr_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tmr_pkg::tmr_word_t pwdata,
  input wire tmr_pkg::tmr_strb_t pstrb,
  output tmr_pkg::tmr_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input_pin,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  output logic match_irq
);
  import tmr_pkg::*;

  // ********************************
  // helpers
  // ********************************
  function automatic logic addr_hit(input tmr_addr_t a);
    addr_hit = (a == `TMR_OFS_MODE) ||
               (a == `TMR_OFS_COUNT) ||
               (a == `TMR_OFS_CMP) ||
               (a == `TMR_OFS_TOE) ||
               (a == `TMR_OFS_STATUS) ||
               (a == `TMR_OFS_IE) ||
               (a == `TMR_OFS_PORT) ||
               (a == `TMR_OFS_RESTART);
  endfunction : addr_hit

  // prescaler wraps its low n bits once per 2^n clocks
  function automatic logic div_tick(input tmr_prediv_t pd, input tmr_freq_t sel);
    logic t;
    t = 1'b0;
    unique case (sel)
      2'h0: t = &pd[`TMR_DIV0_W-1:0];
      2'h1: t = &pd[`TMR_DIV1_W-1:0];
      2'h2: t = &pd[`TMR_DIV2_W-1:0];
      2'h3: t = &pd[`TMR_DIV3_W-1:0];
    endcase
    div_tick = t;
  endfunction : div_tick

  function automatic tmr_cnt_t merge16(input tmr_cnt_t old, input tmr_word_t wd,
                                       input tmr_strb_t sb);
    tmr_cnt_t r;
    r = old;
    if (sb[`TMR_LO_BYTE]) begin
      r[`TMR_BYTE0_RANGE] = wd[`TMR_BYTE0_RANGE];
    end
    if (sb[`TMR_HI_BYTE]) begin
      r[`TMR_BYTE1_RANGE] = wd[`TMR_BYTE1_RANGE];
    end
    merge16 = r;
  endfunction : merge16

  // ********************************
  // state
  // ********************************
  tmr_state_t st_reg;
  tmr_state_t st_next;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_setup;
  logic byte0;
  logic ext_edge;
  logic tick;
  logic match;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite & addr_hit(paddr);
  assign rd_setup = setup_ph & ~pwrite;
  assign byte0 = pstrb[`TMR_LO_BYTE];

  // ********************************
  // count source
  // ********************************
  // only sync2 and sync3 feed the edge detector
  assign ext_edge = st_reg.freq_sel[0] ? (~st_reg.sync2 & st_reg.sync3)
                                       : (st_reg.sync2 & ~st_reg.sync3);

  // external edges or divided clock
  assign tick = st_reg.src_sel ? div_tick(st_reg.prediv, st_reg.freq_sel) : ext_edge;

  assign match = (st_reg.cnt == st_reg.cmp);

  // ********************************
  // next state
  // ********************************
  always_comb begin
    st_next = st_reg;
    st_next.restart = 1'b0;
    st_next.sync1 = ext_count_input_pin;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.prediv = st_reg.prediv + tmr_prediv_t'(1);

    // register writes, taken at the access edge
    if (wr_acc) begin
      unique case (paddr)
        `TMR_OFS_MODE: begin
          // byte write only; unused bits are simply not stored
          if (byte0) begin
            st_next.mode_en = pwdata[`TMR_MODE_EN_BIT];
            st_next.src_sel = pwdata[`TMR_MODE_SRC_BIT];
            st_next.freq_sel = pwdata[`TMR_MODE_FREQ_MSB:`TMR_MODE_FREQ_LSB];
            st_next.restart = pwdata[`TMR_MODE_RESTART_BIT];
          end
        end
        `TMR_OFS_CMP: begin
          st_next.cmp = merge16(st_reg.cmp, pwdata, pstrb);
        end
        `TMR_OFS_TOE: begin
          if (byte0) begin
            st_next.toe = pwdata[`TMR_TOE_BIT];
          end
        end
        `TMR_OFS_STATUS: begin
          if (byte0 && pwdata[`TMR_FLAG_BIT]) begin
            st_next.flag = 1'b0;
          end
        end
        `TMR_OFS_IE: begin
          if (byte0) begin
            st_next.ie = pwdata[`TMR_IE_BIT];
          end
        end
        `TMR_OFS_PORT: begin
          if (byte0) begin
            st_next.port_dir = pwdata[`TMR_PORT_DIR_BIT];
            st_next.port_latch = pwdata[`TMR_PORT_LATCH_BIT];
          end
        end
        `TMR_OFS_RESTART: begin
          // lone restart bit, no other mode bit disturbed
          if (byte0 && pwdata[`TMR_SOLO_RESTART_BIT]) begin
            st_next.restart = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // counter; runs after the writes so a match set beats a flag clear
    if (st_reg.restart) begin
      st_next.cnt = `TMR_CNT_RESET;
      st_next.flag = 1'b0;
      st_next.tol = 1'b0;
      st_next.prediv = '0;
    end else if (st_reg.mode_en && tick) begin
      if (match) begin
        // value stays at compare for one period: compare+1 periods
        st_next.cnt = `TMR_CNT_RESET;
        st_next.flag = 1'b1;
        st_next.tol = ~st_reg.tol;
      end else begin
        st_next.cnt = st_reg.cnt + tmr_cnt_t'(1);
      end
    end

    // pin level; port latch shows whenever the timer does not own it
    if (st_next.toe && st_next.port_dir && !st_next.port_latch) begin
      st_next.pin_out = st_next.tol;
    end else begin
      st_next.pin_out = st_next.port_latch;
    end

    // read data captured in setup, stable through the access phase
    if (rd_setup) begin
      st_next.rdata = '0;
      unique case (paddr)
        `TMR_OFS_COUNT: begin
          st_next.rdata[`TMR_CNT_W-1:0] = st_reg.cnt;
        end
        `TMR_OFS_TOE: begin
          st_next.rdata[`TMR_TOE_BIT] = st_reg.toe;
        end
        `TMR_OFS_STATUS: begin
          st_next.rdata[`TMR_FLAG_BIT] = st_reg.flag;
          st_next.rdata[`TMR_LATCH_BIT] = st_reg.tol;
        end
        `TMR_OFS_IE: begin
          st_next.rdata[`TMR_IE_BIT] = st_reg.ie;
        end
        `TMR_OFS_PORT: begin
          st_next.rdata[`TMR_PORT_DIR_BIT] = st_reg.port_dir;
          st_next.rdata[`TMR_PORT_LATCH_BIT] = st_reg.port_latch;
        end
        default: begin
          // write-only and unmapped words read zero
          st_next.rdata = '0;
        end
      endcase
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= TMR_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************
  // outputs
  // ********************************
  // no wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_hit(paddr);
  assign prdata = st_reg.rdata;
  assign match_irq = st_reg.flag & st_reg.ie;
  assign clock_output_pin = st_reg.pin_out;
  assign clock_output_pin_oe = st_reg.port_dir;

endmodule : tmr16_timer

// ### test/tmr16_timer_sva.sv
// Purpose: port checks of the timer unit
// Assumes: zero wait APB, byte registers in bit 0
// Notes: bound to every tmr16_timer
`timescale 1ns/100ps
// ****
// checker
// ****
module tmr16_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmr_pkg::tmr_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tmr_pkg::tmr_word_t pwdata,
  input wire tmr_pkg::tmr_strb_t pstrb,
  input wire tmr_pkg::tmr_word_t prdata,
  input wire logic pslverr,
  input wire logic clock_output_pin,
  input wire logic clock_output_pin_oe,
  input wire logic match_irq
);
  import tmr_pkg::*;
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite && pstrb[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_mode_rd_zero: assert property (rd && paddr == 12'hFA0 |-> prdata == 32'h0)
    else $error("mode read not zero");
  chk_cmp_rd_zero: assert property (rd && paddr == 12'hFA8 |-> prdata == 32'h0)
    else $error("compare read not zero");
  chk_cnt_upper: assert property (rd && paddr == 12'hFA4 |-> prdata[31:16] == 16'h0)
    else $error("count upper bits set");
  chk_toe_upper: assert property (rd && paddr == 12'hFAC |-> prdata[31:1] == 31'h0)
    else $error("enable flag upper bits set");
  chk_unmapped_err: assert property (rd && paddr == 12'hFC0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_restart_clears: assert property (wr && paddr == 12'hFA0 && pwdata[3] |-> ##[1:3] !match_irq)
    else $error("restart left request high");
  chk_oe_dir: assert property (wr && paddr == 12'hFB8 |=> clock_output_pin_oe == $past(pwdata[0]))
    else $error("pin enable not direction");
  chk_pin_port: assert property (wr && paddr == 12'hFB8 && pwdata[1] |=> ##1 clock_output_pin)
    else $error("pin not port latch");
  chk_irq_mask: assert property (wr && paddr == 12'hFB4 && !pwdata[0] |=> ##1 !match_irq)
    else $error("masked request passed");
  cover property (wr && paddr == 12'hFA0 && pwdata[6]);
  cover property ($rose(match_irq));
  cover property ($rose(clock_output_pin) && clock_output_pin_oe);
endmodule : tmr16_timer_sva

bind tmr16_timer tmr16_timer_sva u_sva (.*);

// ### test/tmr_ext_src.sv
// Purpose: event source and clock output load
// Assumes: count pin idles low between pulses
// Notes: load only counts rising pin edges
`timescale 1ns/100ps
// ****
// model
// ****
module tmr_ext_src (
  input wire logic pclk,
  output logic ext_count_input_pin,
  input wire logic clock_output_pin
);
  int n_rise = 0;
  initial ext_count_input_pin = 1'b0;
  always @(posedge clock_output_pin) n_rise++;
  // slow pulses so the two-flop sync never misses one
  task automatic pulse(int n);
    repeat (n) begin
      repeat (5) @(posedge pclk);
      ext_count_input_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      ext_count_input_pin <= 1'b0;
    end
    repeat (5) @(posedge pclk);
  endtask : pulse
endmodule : tmr_ext_src

// ### test/tmr16_timer_tb_top.sv
// Purpose: self-checking bench of the timer unit
// Assumes: zero wait APB, 100 MHz pclk
// Notes: prescaled rates measured in pclk cycles
`timescale 1ns/100ps
// ****
// bench
// ****
module tmr16_timer_tb_top;
  import tmr_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, ext, pin, oe, irq, qe;
  tmr_addr_t paddr;
  tmr_word_t pwdata, prdata, q;
  tmr_strb_t pstrb;
  int n_fail = 0, checked = 0, cyc = 0, t0, span;
  always #5 pclk = ~pclk;
  tmr16_timer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_input_pin(ext), .clock_output_pin(pin),
    .clock_output_pin_oe(oe), .match_irq(irq));
  tmr_ext_src u_src (.pclk(pclk), .ext_count_input_pin(ext), .clock_output_pin(pin));
  task automatic check(tmr_word_t got, tmr_word_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(logic w, tmr_addr_t a, tmr_word_t d, tmr_strb_t s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(tmr_addr_t a, tmr_word_t d);
    xfer(1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rc(tmr_addr_t a, tmr_word_t e);
    xfer(1'b0, a, '0, 4'h0);
    check(q, e);
  endtask : rc
  task report_and_stop;
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // whole run is near 3000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(12'hFA4, 32'h0);
    rc(12'hFAC, 32'h0);
    rc(12'hFA0, 32'h0);
    rc(12'hFA8, 32'h0);
    rc(12'hFC0, 32'h0);
    check(32'(qe), 32'h1);
    u_src.pulse(1);
    rc(12'hFA4, 32'h0);
    wr(12'hFB4, 32'h1);
    wr(12'hFA8, 32'h1);
    xfer(1'b1, 12'hFA8, 32'h0, 4'h2);
    for (int f = 0; f < 4; f++) begin
      span = 2 << (10 - 2 * f);
      wr(12'hFA0, 32'h4C | (f << 4));
      t0 = cyc;
      // restart lands one edge after the write; skip the stale request
      do @(posedge pclk); while (irq !== 1'b1);
      check(32'(cyc - t0 >= span - 4 && cyc - t0 <= span + 4), 32'h1);
      rc(12'hFA4, 32'h0);
      rc(12'hFB0, 32'h3);
    end
    wr(12'hFB4, 32'h0);
    check(32'(irq), 32'h0);
    xfer(1'b1, 12'hFA8, 32'hFFFF, 4'h3);
    wr(12'hFA0, 32'h0C);
    u_src.pulse(5);
    rc(12'hFA4, 32'h5);
    wr(12'hFA0, 32'h00);
    u_src.pulse(2);
    rc(12'hFA4, 32'h5);
    wr(12'hFA0, 32'h1C);
    u_src.pulse(3);
    rc(12'hFA4, 32'h3);
    xfer(1'b1, 12'hFA8, 32'h1, 4'h3);
    wr(12'hFA0, 32'h0C);
    wr(12'hFB8, 32'h1);
    wr(12'hFAC, 32'h1);
    t0 = u_src.n_rise;
    u_src.pulse(2);
    check(32'(pin), 32'h1);
    u_src.pulse(2);
    check(32'(u_src.n_rise - t0), 32'h1);
    rc(12'hFB0, 32'h1);
    check(32'(irq), 32'h0);
    rc(12'hFAC, 32'h1);
    wr(12'hFB8, 32'h3);
    wr(12'hFBC, 32'h1);
    rc(12'hFB0, 32'h0);
    report_and_stop();
  end
endmodule : tmr16_timer_tb_top
